// ==== inc/fuse_store_defines.svh ====
// constants of the fuse latch and signature store
// assumes inclusion by bare name from the package and design files
`ifndef FUSE_STORE_DEFINES_SVH
`define FUSE_STORE_DEFINES_SVH

// =============================================================
// selector codes for fuse reads and writes and for lock reads, and for signature reads
`define SEL_LOW_FUSE        2'h0
`define SEL_HIGH_FUSE       2'h1
`define SEL_EXT_FUSE        2'h2
`define SEL_LOCK_BYTE       2'h3
`define SIG_ADDR_BYTE0      2'h0
`define SIG_ADDR_BYTE1      2'h1
`define SIG_ADDR_BYTE2      2'h2

// =============================================================
// programmer command codes
`define CMD_CHIP_ERASE      8'h80
`define CMD_WRITE_FUSE      8'h40
`define CMD_WRITE_LOCK      8'h20
`define CMD_READ_SIG        8'h08
`define CMD_READ_FUSE_LOCK  8'h04

// =============================================================
// reset values (unprogrammed reads 1)
`define EXT_FUSE_RESET      8'hFF
`define HIGH_FUSE_RESET     8'hD9
`define LOW_FUSE_RESET      8'h62
`define LOCK_BYTE_RESET     8'hFF

// =============================================================
// field positions
`define HIGH_EXT_RESET_OFF  7
`define HIGH_DEBUG_ON       6
`define HIGH_SERIAL_PERMIT  5
`define HIGH_WDOG_FORCED    4
`define HIGH_KEEP_EEPROM    3
`define HIGH_BOOT_MSB       2
`define HIGH_BOOT_LSB       1
`define HIGH_RESET_VECTOR   0
`define LOW_CLK_DIV8        7
`define LOW_CLK_OUT         6
`define LOW_SUT_MSB         5
`define LOW_SUT_LSB         4
`define LOW_CKSEL_MSB       3
`define LOW_CKSEL_LSB       0
`define EXT_BOD_MSB         2
`define EXT_BOD_LSB         0
`define EXT_SELF_PROG       0
`define LOCK_FIRST_BIT      0
`define PC_WORD_MSB         5
`define PC_PAGE_MSB         13
`define PC_PAGE_LSB         6
`define EE_BYTE_MSB         1
`define EE_PAGE_MSB         9
`define EE_PAGE_LSB         2

`endif

// ==== inc/fuse_store_pkg.sv ====
// types of the fuse latch and signature store
// assumes fuse_store_defines.svh is on the include path
package fuse_store_pkg;
    `include "fuse_store_defines.svh"

    typedef logic [7:0] byte_t;
    typedef logic [1:0] sel_t;

    typedef enum logic [1:0] {LAT_POWERUP, LAT_NORMAL, LAT_PROG} lat_state_t;

    typedef struct packed {
        byte_t ext;
        byte_t high;
        byte_t low;
    } fuse_set_t;

    typedef struct packed {
        lat_state_t lat;
        fuse_set_t  shadow;
        byte_t      lockByte;
        logic       rspValid;
        byte_t      rspData;
        byte_t      rcTrim;
        logic       eraseFlash;
        logic       eraseEeprom;
        logic       writeRefused;
        logic       keepEeprom;
        logic       clockOutPinOn;
        logic       clockDivByEight;
        logic       extResetOff;
        logic       singleWireDebugOn;
        logic       watchdogForcedOn;
        logic       resetVectorSelect;
        logic       selfProgramPermit;
    } main_state_t;

    typedef struct packed {
        logic [5:0] wordInPage;
        logic [7:0] pageIndex;
        logic [1:0] eeByteInPage;
        logic [7:0] eePage;
    } geom_state_t;
endpackage : fuse_store_pkg

// ==== inc/fuse_nv_if.sv ====
// carrier between the store control and its non-volatile fuse cells
// assumes both ends share one clock
`timescale 1ns/1ns
interface fuse_nv_if;
    import fuse_store_pkg::*;
    logic      wrEn;
    sel_t      wrSel;
    byte_t     wrData;
    fuse_set_t cells;

    modport owner (input wrEn, input wrSel, input wrData, output cells);
    modport user  (output wrEn, output wrSel, output wrData, input cells);
endinterface : fuse_nv_if

// ==== src/fuse_nv_cells.sv ====
// non-volatile fuse bytes, written only through the nv carrier
// assumes rst_n is the power-on reset and restores the default fuse bytes
`timescale 1ns/1ns
`include "fuse_store_defines.svh"
module fuse_nv_cells (
    input  wire logic clk,
    input  wire logic rst_n,
    fuse_nv_if.owner  nv
);
    import fuse_store_pkg::*;

    fuse_set_t stateQ;
    fuse_set_t stateD;

    always_comb begin
        stateD = stateQ;
        if (nv.wrEn) begin
            unique case (nv.wrSel)
                `SEL_LOW_FUSE:  stateD.low  = nv.wrData;
                `SEL_HIGH_FUSE: stateD.high = nv.wrData;
                `SEL_EXT_FUSE:  stateD.ext  = nv.wrData;  // R02
                default:        stateD      = stateQ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= {`EXT_FUSE_RESET, `HIGH_FUSE_RESET, `LOW_FUSE_RESET};
        end else begin
            stateQ <= stateD;
        end
    end

    assign nv.cells = stateQ;

    a_cell_write: assert property (@(posedge clk) disable iff (!rst_n)
        nv.wrEn && nv.wrSel == `SEL_LOW_FUSE |=> nv.cells.low == $past(nv.wrData))
        else $error("low fuse byte did not take the write"); // R02
endmodule // fuse_nv_cells

// ==== src/page_geometry_split.sv ====
// splits flash and eeprom addresses into page and in-page fields
// assumes addresses are synchronous to clk
`timescale 1ns/1ns
`include "fuse_store_defines.svh"
module page_geometry_split (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic [13:0]                 pc,
    input  wire logic [9:0]                  eeAddr,
    output fuse_store_pkg::geom_state_t      geom
);
    import fuse_store_pkg::*;

    geom_state_t stateQ;
    geom_state_t stateD;

    always_comb begin
        stateD.wordInPage   = pc[`PC_WORD_MSB:0];                  // R20
        stateD.pageIndex    = pc[`PC_PAGE_MSB:`PC_PAGE_LSB];       // R20
        stateD.eeByteInPage = eeAddr[`EE_BYTE_MSB:0];              // R21
        stateD.eePage       = eeAddr[`EE_PAGE_MSB:`EE_PAGE_LSB];   // R21
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= '0;
        end else begin
            stateQ <= stateD;
        end
    end

    assign geom = stateQ;

    a_flash_page: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 {geom.pageIndex, geom.wordInPage} == $past(pc))
        else $error("flash page split wrong"); // R20
    a_eeprom_page: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 {geom.eePage, geom.eeByteInPage} == $past(eeAddr))
        else $error("eeprom page split wrong"); // R21
endmodule // page_geometry_split

// ==== src/fuse_latch_signature_store.sv ====
// fuse store: nv fuse bytes, latched shadow, signature, rc trim copy
// assumes programmer inputs synchronous to clk, rst_n is power-on
`timescale 1ns/1ns
`include "fuse_store_defines.svh"

// Summary of operation
// [R01] programmed fuse reads 0, blank reads 1
// [R02] three eight-bit fuse bytes: extended, high, low
// [R03] extended bits 2:0 brown-out level, rest 1
// [R04] high byte: reset, debug, serial, watchdog, boot
// [R05] serial permit fuse hidden in serial mode
// [R06] low byte: div8, clock out, start-up, source
// [R07] clock-out fuse puts clock on port B0
// [R08] default start-up is longest delay
// [R09] default boot size 00 is largest
// [R10] keep-eeprom fuse spares eeprom on erase
// [R11] chip erase leaves fuses unchanged
// [R12] first lock bit programmed refuses fuse writes
// [R13] programmer writes fuses before lock bits
// [R14] latch on programming entry, apply on exit
// [R15] keep-eeprom fuse acts immediately
// [R16] latch fuses at power-up in normal mode
// [R17] three signature bytes readable even locked
// [R18] calibration in high byte of address 0
// [R19] every reset copies calibration to trim register
// [R20] flash: 256 pages of 64 words
// [R21] eeprom: 256 pages of 4 bytes
// [R22] shadow drives clock, reset, watchdog, boot, debug
module fuse_latch_signature_store #(
    parameter logic [7:0] SIG_BYTE0  = 8'hA5, // arbitrary value
    parameter logic [7:0] SIG_BYTE1  = 8'h5A, // arbitrary value
    parameter logic [7:0] SIG_BYTE2  = 8'h3C, // arbitrary value
    parameter logic [7:0] CAL_BYTE   = 8'h80,
    parameter bit         SELF_PROG_LAYOUT = 1'b0
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 sysResetReq,
    input  wire logic                 progMode,
    input  wire logic                 serialMode,
    input  wire logic                 cmdValid,
    input  wire fuse_store_pkg::byte_t cmdCode,
    input  wire fuse_store_pkg::sel_t  cmdAddr,
    input  wire logic                 cmdHigh,
    input  wire fuse_store_pkg::byte_t cmdData,
    input  wire logic [13:0]          pc,
    input  wire logic [9:0]           eeAddr,
    output logic                      rspValid,
    output fuse_store_pkg::byte_t     rspData,
    output logic                      eraseFlash,
    output logic                      eraseEeprom,
    output logic                      keepEeprom,
    output logic                      writeRefused,
    output fuse_store_pkg::byte_t     rcTrim,
    output fuse_store_pkg::fuse_set_t fuseLatched,
    output logic [2:0]                brownoutLevel,
    output logic                      selfProgramPermit,
    output logic                      extResetOff,
    output logic                      singleWireDebugOn,
    output logic                      watchdogForcedOn,
    output logic [1:0]                bootSize,
    output logic                      resetVectorSelect,
    output logic                      clockDivByEight,
    output logic                      clockOutPinOn,
    output logic [1:0]                startupTime,
    output logic [3:0]                clockSource,
    output logic [5:0]                wordInPage,
    output logic [7:0]                pageIndex,
    output logic [1:0]                eeByteInPage,
    output logic [7:0]                eePage
);
    import fuse_store_pkg::*;

    // =============================================================
    // sub-blocks
    fuse_nv_if   nv ();
    geom_state_t geom;
    main_state_t stateQ;
    main_state_t stateD;
    logic        progQ;

    fuse_nv_cells u_cells (
        .clk   (clk),
        .rst_n (rst_n),
        .nv    (nv.owner)
    );

    page_geometry_split u_geom (
        .clk    (clk),
        .rst_n  (rst_n),
        .pc     (pc),
        .eeAddr (eeAddr),
        .geom   (geom)
    );

    // =============================================================
    // helpers
    function automatic byte_t sig_read(input sel_t addr, input logic hi);
        byte_t r;
        r = 8'hFF;
        if (hi) begin
            if (addr == `SIG_ADDR_BYTE0) r = CAL_BYTE;         // R18
        end else begin
            unique case (addr)
                `SIG_ADDR_BYTE0: r = SIG_BYTE0;                // R17
                `SIG_ADDR_BYTE1: r = SIG_BYTE1;
                `SIG_ADDR_BYTE2: r = SIG_BYTE2;
                default:         r = 8'hFF;
            endcase
        end
        return r;
    endfunction

    // hides the serial permit bit from a serial-mode reader
    function automatic byte_t guard_high(input byte_t v, input logic ser);
        byte_t r;
        r = v;
        if (ser) r[`HIGH_SERIAL_PERMIT] = 1'b1;                // R05
        return r;
    endfunction

    // =============================================================
    // command decode
    logic isCmd;
    logic lockedFirst;
    logic fuseWrite;
    byte_t wrValue;

    always_comb begin
        isCmd       = cmdValid && progMode;
        lockedFirst = !stateQ.lockByte[`LOCK_FIRST_BIT];
        fuseWrite   = isCmd && cmdCode == `CMD_WRITE_FUSE
                      && cmdAddr != `SEL_LOCK_BYTE;
        wrValue     = cmdData;
        // unused extended bits always read blank
        if (cmdAddr == `SEL_EXT_FUSE) begin
            wrValue[7:3] = 5'h1F;                              // R03
            if (SELF_PROG_LAYOUT) wrValue[2:1] = 2'h3;
        end
        if (serialMode && cmdAddr == `SEL_HIGH_FUSE) begin
            wrValue[`HIGH_SERIAL_PERMIT] =
                nv.cells.high[`HIGH_SERIAL_PERMIT];            // R05
        end
        nv.wrEn   = fuseWrite && !lockedFirst;                 // R12
        nv.wrSel  = cmdAddr;
        nv.wrData = wrValue;
    end

    // =============================================================
    // next state
    always_comb begin
        stateD             = stateQ;
        stateD.rspValid    = 1'b0;
        stateD.eraseFlash  = 1'b0;
        stateD.eraseEeprom = 1'b0;
        stateD.writeRefused = fuseWrite && lockedFirst;        // R12

        unique case (stateQ.lat)
            LAT_POWERUP: begin
                stateD.shadow = nv.cells;                      // R16
                stateD.lat    = progMode ? LAT_PROG : LAT_NORMAL;
            end
            LAT_NORMAL: begin
                if (progMode) begin
                    stateD.shadow = nv.cells;                  // R14
                    stateD.lat    = LAT_PROG;
                end
            end
            LAT_PROG: begin
                if (!progMode) begin
                    stateD.shadow = nv.cells;                  // R14
                    stateD.lat    = LAT_NORMAL;
                end
            end
            default: stateD.lat = LAT_POWERUP;
        endcase

        if (sysResetReq) begin
            stateD.rcTrim = CAL_BYTE;                          // R19
        end

        if (isCmd) begin
            stateD.rspValid = 1'b1;
            stateD.rspData  = 8'hFF;
            unique case (cmdCode)
                `CMD_CHIP_ERASE: begin
                    stateD.eraseFlash  = 1'b1;                 // R11
                    stateD.eraseEeprom =
                        nv.cells.high[`HIGH_KEEP_EEPROM];      // R10 R15
                    stateD.lockByte    = `LOCK_BYTE_RESET;
                end
                `CMD_WRITE_LOCK: begin
                    stateD.lockByte = stateQ.lockByte & cmdData;
                end
                `CMD_READ_SIG: begin
                    stateD.rspData = sig_read(cmdAddr, cmdHigh); // R17
                end
                `CMD_READ_FUSE_LOCK: begin
                    unique case (cmdAddr)
                        `SEL_LOW_FUSE:  stateD.rspData = nv.cells.low;
                        `SEL_HIGH_FUSE: stateD.rspData =
                            guard_high(nv.cells.high, serialMode); // R05
                        `SEL_EXT_FUSE:  stateD.rspData = nv.cells.ext;
                        default:        stateD.rspData = stateQ.lockByte;
                    endcase
                end
                default: stateD.rspData = 8'hFF;
            endcase
        end

        // decoded flags, active when the fuse is programmed (reads 0)
        stateD.keepEeprom = !nv.cells.high[`HIGH_KEEP_EEPROM];    // R15
        stateD.clockOutPinOn =
            !stateD.shadow.low[`LOW_CLK_OUT];                     // R07
        stateD.clockDivByEight = !stateD.shadow.low[`LOW_CLK_DIV8];
        stateD.extResetOff =
            !stateD.shadow.high[`HIGH_EXT_RESET_OFF];             // R22
        stateD.singleWireDebugOn = !stateD.shadow.high[`HIGH_DEBUG_ON]; // R04
        stateD.watchdogForcedOn  = !stateD.shadow.high[`HIGH_WDOG_FORCED];
        stateD.resetVectorSelect = !stateD.shadow.high[`HIGH_RESET_VECTOR];
        stateD.selfProgramPermit = SELF_PROG_LAYOUT
            && !stateD.shadow.ext[`EXT_SELF_PROG];                // R03
    end

    // =============================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ          <= '0;
            stateQ.lat      <= LAT_POWERUP;
            stateQ.shadow   <= {`EXT_FUSE_RESET, `HIGH_FUSE_RESET,
                                `LOW_FUSE_RESET};
            stateQ.lockByte <= `LOCK_BYTE_RESET;
            stateQ.rspData  <= 8'hFF;
            stateQ.rcTrim   <= CAL_BYTE;                       // R19
        end else begin
            stateQ <= stateD;
        end
    end

    // programming mode seen last cycle, only for the checks below
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            progQ <= 1'b0;
        end else begin
            progQ <= progMode;
        end
    end

    // =============================================================
    // outputs
    assign rspValid          = stateQ.rspValid;
    assign rspData           = stateQ.rspData;
    assign eraseFlash        = stateQ.eraseFlash;
    assign eraseEeprom       = stateQ.eraseEeprom;
    assign keepEeprom        = stateQ.keepEeprom;
    assign writeRefused      = stateQ.writeRefused;
    assign rcTrim            = stateQ.rcTrim;
    assign fuseLatched       = stateQ.shadow;                  // R01
    assign brownoutLevel     =
        stateQ.shadow.ext[`EXT_BOD_MSB:`EXT_BOD_LSB];          // R03
    assign selfProgramPermit = stateQ.selfProgramPermit;
    assign extResetOff       = stateQ.extResetOff;
    assign singleWireDebugOn = stateQ.singleWireDebugOn;
    assign watchdogForcedOn  = stateQ.watchdogForcedOn;
    assign bootSize          =
        stateQ.shadow.high[`HIGH_BOOT_MSB:`HIGH_BOOT_LSB];     // R09
    assign resetVectorSelect = stateQ.resetVectorSelect;
    assign clockDivByEight   = stateQ.clockDivByEight;
    assign clockOutPinOn     = stateQ.clockOutPinOn;
    assign startupTime       =
        stateQ.shadow.low[`LOW_SUT_MSB:`LOW_SUT_LSB];          // R08
    assign clockSource       =
        stateQ.shadow.low[`LOW_CKSEL_MSB:`LOW_CKSEL_LSB];      // R06
    assign wordInPage        = geom.wordInPage;
    assign pageIndex         = geom.pageIndex;
    assign eeByteInPage      = geom.eeByteInPage;
    assign eePage            = geom.eePage;

    // =============================================================
    // checks
    sequence s_prog_entry;
        !progQ ##1 progMode && stateQ.lat == LAT_NORMAL;
    endsequence

    sequence s_prog_hold;
        progQ && progMode && stateQ.lat == LAT_PROG;
    endsequence

    a_lock_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        lockedFirst |=> $stable(nv.cells))
        else $error("fuse write accepted while locked"); // R12
    a_lock_refused: assert property (@(posedge clk) disable iff (!rst_n)
        fuseWrite && lockedFirst |=> writeRefused && $stable(nv.cells))
        else $error("locked write not refused"); // R12
    a_erase_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        isCmd && cmdCode == `CMD_CHIP_ERASE |=> $stable(nv.cells)
            && eraseFlash && lockByte_erased())
        else $error("chip erase disturbed fuses"); // R11
    a_keep_eeprom: assert property (@(posedge clk) disable iff (!rst_n)
        eraseEeprom |-> $past(nv.cells.high[`HIGH_KEEP_EEPROM]))
        else $error("eeprom erased while kept"); // R10
    a_entry_latch: assert property (@(posedge clk) disable iff (!rst_n)
        s_prog_entry |=> fuseLatched == $past(nv.cells))
        else $error("fuses not latched on entry"); // R14
    a_prog_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        s_prog_hold ##1 progMode |-> $stable(fuseLatched))
        else $error("shadow changed inside programming"); // R14
    a_serial_guard: assert property (@(posedge clk) disable iff (!rst_n)
        nv.wrEn && serialMode && cmdAddr == `SEL_HIGH_FUSE |=>
            $stable(nv.cells.high[`HIGH_SERIAL_PERMIT]))
        else $error("serial permit written in serial mode"); // R05
    a_sig_read: assert property (@(posedge clk) disable iff (!rst_n)
        isCmd && cmdCode == `CMD_READ_SIG && !cmdHigh
            && cmdAddr == `SIG_ADDR_BYTE1 |=> rspValid && rspData == SIG_BYTE1)
        else $error("signature byte read wrong"); // R17
    a_rc_trim: assert property (@(posedge clk) disable iff (!rst_n)
        sysResetReq |=> rcTrim == CAL_BYTE)
        else $error("trim not reloaded on reset"); // R19
    a_clock_out: assert property (@(posedge clk) disable iff (!rst_n)
        stateQ.lat != LAT_POWERUP |-> clockOutPinOn
            == !fuseLatched.low[`LOW_CLK_OUT])
        else $error("clock output pin flag wrong"); // R07

    function automatic logic lockByte_erased();
        return stateQ.lockByte == `LOCK_BYTE_RESET;
    endfunction
endmodule // fuse_latch_signature_store

// ==== verif/fuse_programmer_model.sv ====
// programmer model: single-byte commands into the fuse store
// assumes clk is the store clock and rsp is one cycle after take
`timescale 1ns/1ns
module fuse_programmer_model (
    input  wire logic                  clk,
    input  wire logic                  rspValid,
    input  wire fuse_store_pkg::byte_t rspData,
    output logic                       cmdValid,
    output fuse_store_pkg::byte_t      cmdCode,
    output fuse_store_pkg::sel_t       cmdAddr,
    output logic                       cmdHigh,
    output fuse_store_pkg::byte_t      cmdData
);
    import fuse_store_pkg::*;
    initial begin
        cmdValid = 1'b0;
        cmdCode = 8'h00;
        cmdAddr = 2'h0;
        cmdHigh = 1'b0;
        cmdData = 8'h00;
    end
    task automatic issue(input byte_t c, input sel_t a, input logic h,
                         input byte_t dt, output logic v, output byte_t rd);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdCode <= c;
        cmdAddr <= a;
        cmdHigh <= h;
        cmdData <= dt;
        @(posedge clk);
        cmdValid <= 1'b0;
        cmdData <= ~dt;
        #1;
        v = rspValid;
        rd = rspData;
    endtask
endmodule // fuse_programmer_model

// ==== verif/test_fuse_latch_signature_store.sv ====
// bench: fuse store against an integer model of the fuse bytes
// assumes the programmer model drives the command port
`timescale 1ns/1ns
module test_fuse_latch_signature_store;
    import fuse_store_pkg::*;
    localparam byte_t CAL = 8'h9B;
    localparam byte_t SIG [3] = '{8'h3E, 8'hC1, 8'h77}; // arbitrary values
    logic clk = 0, rst_n = 0, sysResetReq = 0, progMode = 0, serialMode = 0;
    logic [13:0] pc = 0;
    logic [9:0] eeAddr = 0;
    logic cmdValid, cmdHigh, rspValid, eraseFlash, eraseEeprom, keepEeprom;
    logic writeRefused, clockDivByEight, clockOutPinOn, v, selfProgramPermit;
    logic singleWireDebugOn, watchdogForcedOn, extResetOff, resetVectorSelect;
    byte_t cmdCode, cmdData, rspData, rcTrim, d, x, pageIndex, eePage;
    sel_t cmdAddr;
    fuse_set_t fuseLatched;
    logic [1:0] bootSize, startupTime, eeByteInPage;
    logic [2:0] brownoutLevel;
    logic [3:0] clockSource;
    logic [5:0] wordInPage;
    int fail_count = 0, check_count = 0, nv [3] = '{8'h62, 8'hD9, 8'hFF};
    int unsigned seed = 93;
    always #4 clk = ~clk;
    fuse_latch_signature_store #(.SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]),
        .SIG_BYTE2(SIG[2]), .CAL_BYTE(CAL)) fuse_latch_signature_store_inst (
        .clk(clk), .rst_n(rst_n), .sysResetReq(sysResetReq),
        .progMode(progMode), .serialMode(serialMode), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdHigh(cmdHigh),
        .cmdData(cmdData), .pc(pc), .eeAddr(eeAddr), .rspValid(rspValid),
        .rspData(rspData), .eraseFlash(eraseFlash), .eraseEeprom(eraseEeprom),
        .keepEeprom(keepEeprom), .writeRefused(writeRefused), .rcTrim(rcTrim),
        .fuseLatched(fuseLatched), .brownoutLevel(brownoutLevel),
        .selfProgramPermit(selfProgramPermit), .extResetOff(extResetOff),
        .singleWireDebugOn(singleWireDebugOn),
        .watchdogForcedOn(watchdogForcedOn), .bootSize(bootSize),
        .resetVectorSelect(resetVectorSelect),
        .clockDivByEight(clockDivByEight),
        .clockOutPinOn(clockOutPinOn), .startupTime(startupTime),
        .clockSource(clockSource), .wordInPage(wordInPage),
        .pageIndex(pageIndex), .eeByteInPage(eeByteInPage), .eePage(eePage));
    fuse_programmer_model fuse_programmer_model_inst (
        .clk(clk), .rspValid(rspValid), .rspData(rspData),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdAddr(cmdAddr),
        .cmdHigh(cmdHigh), .cmdData(cmdData));
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input byte_t c, input sel_t a, input logic h,
                       input byte_t dt);
        fuse_programmer_model_inst.issue(c, a, h, dt, v, d);
        check(v, 1'b1);
    endtask
    task automatic prog(input logic m);
        @(posedge clk);
        progMode <= m;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ============================================================
    // watchdog
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
    // ============================================================
    // scenarios
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(fuseLatched, 24'hFFD962);
        check(brownoutLevel, 3'h7);
        check({clockDivByEight, startupTime, clockSource}, 7'h62);
        check({bootSize, singleWireDebugOn, watchdogForcedOn, extResetOff,
               resetVectorSelect, selfProgramPermit}, 7'h00);
        check(rcTrim, CAL);
        repeat (4) begin
            @(posedge clk);
            pc <= 14'(xs());
            eeAddr <= 10'(xs());
            repeat (2) @(posedge clk);
            #1;
            check({pageIndex, wordInPage}, pc);
            check({eePage, eeByteInPage}, eeAddr);
        end
        $display("test 1 done");
        prog(1'b1);
        for (int i = 0; i < 3; i++) begin
            cmd(8'h08, sel_t'(i), 1'b0, 8'h00);
            check(d, SIG[i]);
            cmd(8'h04, sel_t'(i), 1'b0, 8'h00);
            check(d, nv[i]);
        end
        cmd(8'h08, 2'h0, 1'b1, 8'h00);
        check(d, CAL);
        @(posedge clk);
        serialMode <= 1'b1;
        cmd(8'h40, 2'h1, 1'b0, 8'hF9);
        nv[1] = (8'hF9 & 8'hDF) | (nv[1] & 8'h20);
        cmd(8'h04, 2'h1, 1'b0, 8'h00);
        check(d, nv[1] | 8'h20);
        @(posedge clk);
        serialMode <= 1'b0;
        cmd(8'h04, 2'h1, 1'b0, 8'h00);
        check(d, nv[1]);
        cmd(8'h80, 2'h0, 1'b0, 8'h00);
        check({eraseFlash, eraseEeprom}, 2'h3);
        $display("test 2 done");
        x = byte_t'(xs());
        cmd(8'h40, 2'h0, 1'b0, x);
        nv[0] = x;
        cmd(8'h40, 2'h1, 1'b0, 8'h41);
        nv[1] = 8'h41;
        cmd(8'h40, 2'h2, 1'b0, 8'h00);
        nv[2] = 8'hF8;
        @(posedge clk);
        #1;
        check(keepEeprom, 1'b1);
        check(fuseLatched, 24'hFFD962);
        cmd(8'h80, 2'h0, 1'b0, 8'h00);
        check({eraseFlash, eraseEeprom}, 2'h2);
        for (int i = 0; i < 3; i++) begin
            cmd(8'h04, sel_t'(i), 1'b0, 8'h00);
            check(d, nv[i]);
        end
        prog(1'b0);
        check(fuseLatched, {nv[2][7:0], nv[1][7:0], nv[0][7:0]});
        check(clockOutPinOn, !x[6]);
        check({extResetOff, watchdogForcedOn, singleWireDebugOn,
               resetVectorSelect}, 4'hC);
        $display("test 3 done");
        prog(1'b1);
        cmd(8'h20, 2'h3, 1'b0, 8'hFE);
        cmd(8'h40, 2'h0, 1'b0, ~x);
        check(writeRefused, 1'b1);
        cmd(8'h04, 2'h3, 1'b0, 8'h00);
        check(d, 8'hFE);
        cmd(8'h04, 2'h0, 1'b0, 8'h00);
        check(d, nv[0]);
        cmd(8'h08, 2'h2, 1'b0, 8'h00);
        check(d, SIG[2]);
        prog(1'b0);
        fuse_programmer_model_inst.issue(8'h08, 2'h0, 1'b0, 8'h00, v, d);
        check(v, 1'b0);
        @(posedge clk);
        sysResetReq <= 1'b1;
        @(posedge clk);
        sysResetReq <= 1'b0;
        @(posedge clk);
        #1;
        check(rcTrim, CAL);
        $display("test 4 done");
        stop_test();
    end
endmodule // test_fuse_latch_signature_store
